// File: src/rspb_pkg.sv
// package for the radio setup parameter bank: offsets, resets, carriers
// assumes byte-wide plain register port, one clock, sync reset
package rspb_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [9:0] OFF_WAKE_THRESH = 10'h108;
  localparam logic [9:0] OFF_CARRIER_B0 = 10'h109;
  localparam logic [9:0] OFF_CARRIER_B1 = 10'h10a;
  localparam logic [9:0] OFF_CARRIER_B2 = 10'h10b;
  localparam logic [9:0] OFF_RATE_LOW = 10'h10c;
  localparam logic [9:0] OFF_RATE_DEV_HIGH = 10'h10d;
  localparam logic [9:0] OFF_DEV_LOW = 10'h10e;
  localparam logic [9:0] OFF_CORR_WIDTH = 10'h10f;
  localparam logic [9:0] OFF_POST_FILTER = 10'h110;
  localparam logic [9:0] OFF_SPARE = 10'h111;
  localparam logic [9:0] OFF_LOOP_PHASE = 10'h112;
  // control byte of own choosing: loop table select in [5:4]
  localparam logic [9:0] OFF_LOOP_SELECT = 10'h113;
  localparam int SEL_LSB = 4;
  // ************************************************************
  // reset values and derived constants
  // ************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_POST_FILTER = 8'h01;
  localparam logic [8:0] THRESH_OFFSET_DBM = 9'h06b;
  localparam logic [11:0] RATE_STEP_BPS = 12'h064;
  localparam logic [11:0] DEV_STEP_HZ = 12'h064;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  typedef enum logic [1:0] {
    RSPB_LUT_PREDEF = 2'b00,
    RSPB_LUT_CUST_RX = 2'b01,
    RSPB_LUT_CUST_TX = 2'b10,
    RSPB_LUT_CUST_BOTH = 2'b11
  } rspb_lut_type;

  typedef struct packed {
    logic [7:0] wake_signal_threshold;
    logic [7:0] carrier_word_byte0;
    logic [7:0] carrier_word_byte1;
    logic [7:0] carrier_word_byte2;
    logic [7:0] bit_rate_low;
    logic [7:0] rate_and_deviation_high;
    logic [7:0] tone_deviation_low;
    logic [7:0] correlator_width;
    logic [7:0] post_filter_width;
    logic [7:0] spare_zero_byte;
    logic [7:0] loop_tuning_and_phase;
    logic [7:0] loop_select_byte;
  } rspb_regs_type;

  typedef struct packed {
    logic signed [8:0] wake_thresh_dbm;
    logic [23:0] carrier_word;
    logic [11:0] data_rate_code;
    logic [11:0] tone_offset_code;
    logic [7:0] correlator_width_code;
    logic [1:0] correlator_phase_code;
    logic [8:0] post_filter_khz;
    logic [5:0] rx_loop_tuning_low;
    logic rx_loop_custom;
    logic tx_loop_custom;
    logic [1:0] loop_table_select;
  } rspb_cfg_type;

  typedef struct packed {
    rspb_regs_type regs;
    rspb_cfg_type cfg;
    logic [7:0] rdata;
  } rspb_state_type;
endpackage : rspb_pkg

// File: src/rspb_bank.sv
// radio setup parameter bank: byte registers and derived radio settings
// assumes a same-clock master on a plain strobe port, read data next cycle
// Notes on behaviour
// R1: threshold dBm equals byte minus 107
// R2: carrier word from three bytes, low first
// R3: 12-bit rate code, times 100 bps
// R4: 12-bit deviation code, times 100 Hz
// R5: correlator width byte sets demod bandwidth
// R6: post filter kHz equals twice the byte
// R7: software never loads zero filter width
// R8: software picks filter near 0.75 rate
// R9: loop tuning used only for select 1/3
// R10: low two bits set correlator phase
// R11: loop select encodes predefined/custom tables
// R12: bytes read back as written; spare zero (the spare byte stores and returns whatever is written to it)
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module rspb_bank (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output rspb_pkg::rspb_cfg_type o_cfg
);
  // ************************************************************
  // state
  // ************************************************************
  rspb_pkg::rspb_state_type state_r;
  rspb_pkg::rspb_state_type state_nxt;
  rspb_pkg::rspb_regs_type rg;

  // ************************************************************
  // read mux
  // ************************************************************
  function automatic logic [7:0] read_mux(
    input rspb_pkg::rspb_regs_type r,
    input logic [9:0] a
  );
    logic [7:0] v;
    v = rspb_pkg::READ_UNMAPPED;
    if (a == rspb_pkg::OFF_WAKE_THRESH) begin
      v = r.wake_signal_threshold;
    end else if (a == rspb_pkg::OFF_CARRIER_B0) begin
      v = r.carrier_word_byte0;
    end else if (a == rspb_pkg::OFF_CARRIER_B1) begin
      v = r.carrier_word_byte1;
    end else if (a == rspb_pkg::OFF_CARRIER_B2) begin
      v = r.carrier_word_byte2;
    end else if (a == rspb_pkg::OFF_RATE_LOW) begin
      v = r.bit_rate_low;
    end else if (a == rspb_pkg::OFF_RATE_DEV_HIGH) begin
      v = r.rate_and_deviation_high;
    end else if (a == rspb_pkg::OFF_DEV_LOW) begin
      v = r.tone_deviation_low;
    end else if (a == rspb_pkg::OFF_CORR_WIDTH) begin
      v = r.correlator_width;
    end else if (a == rspb_pkg::OFF_POST_FILTER) begin
      v = r.post_filter_width;
    end else if (a == rspb_pkg::OFF_SPARE) begin
      v = r.spare_zero_byte;
    end else if (a == rspb_pkg::OFF_LOOP_PHASE) begin
      v = r.loop_tuning_and_phase;
    end else if (a == rspb_pkg::OFF_LOOP_SELECT) begin
      v = r.loop_select_byte;
    end
    return v;
  endfunction : read_mux

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    rg = state_r.regs;
    state_nxt = state_r;
    if (i_wr) begin
      // plain storage, read back unchanged; see R12
      if (i_addr == rspb_pkg::OFF_WAKE_THRESH) begin
        rg.wake_signal_threshold = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_CARRIER_B0) begin
        rg.carrier_word_byte0 = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_CARRIER_B1) begin
        rg.carrier_word_byte1 = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_CARRIER_B2) begin
        rg.carrier_word_byte2 = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_RATE_LOW) begin
        rg.bit_rate_low = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_RATE_DEV_HIGH) begin
        rg.rate_and_deviation_high = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_DEV_LOW) begin
        rg.tone_deviation_low = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_CORR_WIDTH) begin
        rg.correlator_width = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_POST_FILTER) begin
        // zero is not blocked; software keeps 1..255, see R7
        rg.post_filter_width = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_SPARE) begin
        rg.spare_zero_byte = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_LOOP_PHASE) begin
        rg.loop_tuning_and_phase = i_wdata;
      end else if (i_addr == rspb_pkg::OFF_LOOP_SELECT) begin
        rg.loop_select_byte = i_wdata;
      end
    end
    state_nxt.regs = rg;
    // read data stands one cycle after the strobe only
    if (i_rd) begin
      state_nxt.rdata = read_mux(state_r.regs, i_addr);
    end else begin
      state_nxt.rdata = rspb_pkg::READ_UNMAPPED;
    end
    // derived settings update on the same edge as the stored bytes
    state_nxt.cfg.wake_thresh_dbm =
      $signed({1'b0, rg.wake_signal_threshold})
      - $signed(rspb_pkg::THRESH_OFFSET_DBM); // see R1
    state_nxt.cfg.carrier_word = {rg.carrier_word_byte2,
      rg.carrier_word_byte1, rg.carrier_word_byte0}; // see R2
    state_nxt.cfg.data_rate_code =
      {rg.rate_and_deviation_high[3:0], rg.bit_rate_low}; // see R3
    state_nxt.cfg.tone_offset_code =
      {rg.rate_and_deviation_high[7:4], rg.tone_deviation_low}; // see R4
    state_nxt.cfg.correlator_width_code = rg.correlator_width; // see R5
    state_nxt.cfg.correlator_phase_code =
      rg.loop_tuning_and_phase[1:0]; // see R10
    state_nxt.cfg.post_filter_khz =
      {rg.post_filter_width, 1'b0}; // see R6
    state_nxt.cfg.loop_table_select =
      rg.loop_select_byte[rspb_pkg::SEL_LSB +: 2]; // see R11
    state_nxt.cfg.rx_loop_custom =
      rg.loop_select_byte[rspb_pkg::SEL_LSB]; // see R11
    state_nxt.cfg.tx_loop_custom =
      rg.loop_select_byte[rspb_pkg::SEL_LSB + 1]; // see R11
    // tuning reaches the synthesizer only for custom rx tables
    if (rg.loop_select_byte[rspb_pkg::SEL_LSB]) begin
      state_nxt.cfg.rx_loop_tuning_low =
        rg.loop_tuning_and_phase[7:2]; // see R9
    end else begin
      state_nxt.cfg.rx_loop_tuning_low = 6'h00; // see R9
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r <= '0;
      state_r.regs.post_filter_width <= rspb_pkg::RST_POST_FILTER;
      // derived fields must match the reset bytes, not plain zero
      state_r.cfg.post_filter_khz <= {rspb_pkg::RST_POST_FILTER, 1'b0};
      state_r.cfg.wake_thresh_dbm <=
        $signed(9'h000 - rspb_pkg::THRESH_OFFSET_DBM);
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_rdata = state_r.rdata;
  assign o_cfg = state_r.cfg;
endmodule : rspb_bank

// File: sim/rspb_props.sv
// checker for the radio setup parameter bank ports
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ns
module rspb_props (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire rspb_pkg::rspb_cfg_type o_cfg
);
  // ********
  // properties
  // ********
  default clocking dflt @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr(a);
    i_wr && i_addr == a;
  endsequence
  sequence s_rd_done;
    i_rd ##1 !i_rd;
  endsequence
  a_thresh_map: assert property (s_wr(rspb_pkg::OFF_WAKE_THRESH) |=>
    o_cfg.wake_thresh_dbm == 9'({1'b0, $past(i_wdata)} - 9'd107))
    else $error("threshold wrong");
  a_carrier_top: assert property (s_wr(rspb_pkg::OFF_CARRIER_B2) |=>
    o_cfg.carrier_word[23:16] == $past(i_wdata)) else $error("carrier wrong");
  a_shared_nibbles: assert property (s_wr(rspb_pkg::OFF_RATE_DEV_HIGH) |=>
    {o_cfg.tone_offset_code[11:8], o_cfg.data_rate_code[11:8]} ==
    $past(i_wdata)) else $error("rate or deviation wrong");
  a_corr_width: assert property (s_wr(rspb_pkg::OFF_CORR_WIDTH) |=>
    o_cfg.correlator_width_code == $past(i_wdata)) else $error("width wrong");
  a_filter_double: assert property (s_wr(rspb_pkg::OFF_POST_FILTER) |=>
    o_cfg.post_filter_khz == {$past(i_wdata), 1'b0}) else $error("filter wrong");
  a_phase_low: assert property (s_wr(rspb_pkg::OFF_LOOP_PHASE) |=>
    o_cfg.correlator_phase_code == $past(i_wdata[1:0])) else $error("phase wrong");
  a_tuning_gate: assert property (!o_cfg.loop_table_select[0] |->
    o_cfg.rx_loop_tuning_low == 6'h00) else $error("tuning not gated");
  a_select_flags: assert property (1'b1 |->
    {o_cfg.tx_loop_custom, o_cfg.rx_loop_custom} == o_cfg.loop_table_select)
    else $error("table flags wrong");
  a_read_idle: assert property (s_rd_done |=> o_rdata == 8'h00)
    else $error("read data held");
  a_read_unmapped: assert property (i_rd && (i_addr < 10'h108 ||
    i_addr > 10'h113) |=> o_rdata == 8'h00) else $error("unmapped read");
endmodule : rspb_props
bind rspb_bank rspb_props u_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_cfg(o_cfg));

// File: sim/rspb_tb.sv
// self-checking bench for the radio setup parameter bank
// assumes reads answer one cycle later and no wait states
`timescale 1ns/1ns
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  logic i_ref_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, rd_d = 0;
  logic [9:0] i_addr = '0;
  logic [7:0] i_wdata = '0, o_rdata, d, m [12];
  logic [7:0] exp_q [$];
  rspb_pkg::rspb_cfg_type o_cfg;
  int errors = 0, samples_checked = 0;
  rspb_bank dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_cfg(o_cfg));
  // ********
  // bus tasks and checks
  // ********
  always #2 i_ref_clk = ~i_ref_clk;
  function automatic bit inr(input logic [9:0] a);
    return a >= 10'h108 && a <= 10'h113;
  endfunction : inr
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    i_rd <= 1'b0;
    if (inr(a)) m[a - 10'h108] = v;
  endtask : wr
  task automatic rd(input logic [9:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wr <= 1'b0;
    i_rd <= 1'b1;
    exp_q.push_back(inr(a) ? m[a - 10'h108] : 8'h00);
  endtask : rd
  task automatic idle();
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask : idle
  task automatic tally_and_finish();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // reads answer in the next cycle only, so the note is one edge behind
  always @(posedge i_ref_clk) begin
    if (rd_d) begin
      d = exp_q.pop_front();
      `CHK("o_rdata", d, o_rdata)
    end
    rd_d <= i_rd;
  end
  task automatic chk_cfg(input logic [1:0] s);
    idle();
    idle();
    `CHK("thresh", 9'({1'b0, m[0]} - 9'd107), o_cfg.wake_thresh_dbm)
    `CHK("carrier", {m[3], m[2], m[1]}, o_cfg.carrier_word)
    `CHK("rate", {m[5][3:0], m[4]}, o_cfg.data_rate_code)
    `CHK("dev", {m[5][7:4], m[6]}, o_cfg.tone_offset_code)
    `CHK("width", m[7], o_cfg.correlator_width_code)
    `CHK("filter", {m[8], 1'b0}, o_cfg.post_filter_khz)
    `CHK("phase", m[10][1:0], o_cfg.correlator_phase_code)
    `CHK("tune", s[0] ? m[10][7:2] : 6'h00, o_cfg.rx_loop_tuning_low)
    `CHK("sel", {s, s}, {o_cfg.tx_loop_custom, o_cfg.rx_loop_custom,
      o_cfg.loop_table_select})
  endtask : chk_cfg
  initial begin
    repeat (5000) @(posedge i_ref_clk);
    errors++;
    tally_and_finish();
  end
  // ********
  // main sequence
  // ********
  initial begin
    void'($urandom(32'hb1c5aa06));
    for (int i = 0; i < 12; i++) m[i] = (i == 8) ? 8'h01 : 8'h00;
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 13; i++) rd(10'h108 + 10'(i));
    rd(10'h000);
    chk_cfg(2'd0);
    // odd selects go in before tuning, even ones after, so no gap breaks it
    for (int s = 0; s < 4; s++) begin
      for (int j = 0; j < 12; j++) begin
        automatic int i = s[0] ? 11 - j : j;
        d = 8'($urandom);
        if (i == 8) d = 8'(({m[5][3:0], m[4]} * 3) / 80);
        if (i == 8 && d == 8'h00) d = 8'h01;
        if (i == 9) d = 8'h00;
        if (i == 10 && !s[0]) d[7:2] = 6'h00;
        if (i == 11) d[5:4] = 2'(s);
        wr(10'h108 + 10'(i), d);
        rd(10'h108 + 10'(i));
      end
      wr(10'h114, 8'($urandom));
      rd(10'h114);
      chk_cfg(2'(s));
    end
    tally_and_finish();
  end
endmodule : testbench
